// *** design/tcds_pkg.sv ***
// Purpose: Shared constants and types for the tape control data, status and counter core.
// Assumes: One 10 MHz clock; Avalon-MM register slave with 32-bit data.
// Notes: Holding register positions run 1 to 12; positions 5 to 12 carry byte bits 0 to 7.
package tcds_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] TCDS_OFF_CTRL = 8'h00;
  localparam logic [7:0] TCDS_OFF_CMD = 8'h04;
  localparam logic [7:0] TCDS_OFF_UNITS = 8'h08;
  localparam logic [7:0] TCDS_OFF_STSET = 8'h0C;
  localparam logic [7:0] TCDS_OFF_STATUS = 8'h10;
  localparam logic [7:0] TCDS_OFF_HOLD = 8'h14;
  localparam logic [7:0] TCDS_OFF_COUNT = 8'h18;

  // Control register fields.
  localparam int TCDS_CTRL_RDFWD = 0;
  localparam int TCDS_CTRL_RDBWD = 1;
  localparam int TCDS_CTRL_WRITE = 2;
  localparam int TCDS_CTRL_SENSE = 3;
  localparam int TCDS_CTRL_WDISC = 4;
  localparam int TCDS_CTRL_EOB = 5;
  localparam int TCDS_CTRL_MECH = 6;
  localparam int TCDS_CTRL_STOPDLY = 7;
  localparam logic [7:0] TCDS_CTRL_RESET = 8'h00;

  // Command register pulse fields.
  localparam int TCDS_CMD_PRESENT = 0;
  localparam int TCDS_CMD_START = 1;
  localparam int TCDS_CMD_CONTROL = 2;
  localparam int TCDS_CMD_ENDOP = 3;
  localparam int TCDS_CMD_MRESET = 4;

  // Status byte bit positions (bit 0 is the leftmost byte position).
  localparam int TCDS_SB_MODIFIER = 1;
  localparam int TCDS_SB_CUEND = 2;
  localparam int TCDS_SB_BUSY = 3;
  localparam int TCDS_SB_CHEND = 4;
  localparam int TCDS_SB_DEVEND = 5;
  localparam int TCDS_SB_UNITCHK = 6;
  localparam int TCDS_SB_UNITEXC = 7;
  localparam logic [7:0] TCDS_SB_BASIC_MASK = 8'hF4;
  localparam logic [7:0] TCDS_SB_BUSY_MASK = 8'h0A;

  // Holding register geometry.
  localparam int TCDS_HR_BITS = 12;
  localparam int TCDS_HR_BASE = 5;
  localparam int TCDS_HR_CUEND_POS = 7;
  localparam int TCDS_HR_SPLIT = 6;

  // Counter geometry and counts.
  localparam int TCDS_CNT_BITS = 11;
  localparam logic [10:0] TCDS_MASK_ALL = 11'h7FF;
  localparam logic [10:0] TCDS_MASK_WRITE = 11'h00F;
  localparam logic [10:0] TCDS_MASK_WDISC = 11'h01F;
  localparam logic [10:0] TCDS_MASK_SENSE = 11'h007;
  localparam logic [10:0] TCDS_CNT_CHECK = 11'h600;
  localparam logic [3:0] TCDS_WC_LAST = 4'hF;
  localparam logic [3:0] TCDS_RC_LOAD = 4'h8;
  localparam logic [3:0] TCDS_RC_SENSE = 4'h7;
  localparam logic [2:0] TCDS_SENSE_UNITS = 3'h1;

  // Oscillator rates and derived cycle counts at the 10 MHz clock.
  localparam int TCDS_CLK_HZ = 10000000;
  localparam int TCDS_SLOW_HZ = 5000;
  localparam int TCDS_FAST_HZ = 240000;
  localparam int TCDS_SLOW_DIV = TCDS_CLK_HZ / TCDS_SLOW_HZ;
  localparam int TCDS_FAST_DIV = TCDS_CLK_HZ / TCDS_FAST_HZ;

  // Counter drive modes.
  typedef enum logic [2:0] {
    TCDS_MODE_IDLE,
    TCDS_MODE_WRITE,
    TCDS_MODE_WDISC,
    TCDS_MODE_EOB,
    TCDS_MODE_MECH,
    TCDS_MODE_SENSE
  } tcds_mode_type;

endpackage

// *** design/tcds_counter.sv ***
// Purpose: Eleven-stage toggle counter used as write clock, delay and sense counter.
// Assumes: Drive is a one-cycle enable pulse; stage mask blocks stages that must not run.
// Notes: The ripple behaviour is evaluated within one clock, so all stages settle together.
module tcds_counter (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic hold_reset, // Holds every stage off while no drive is gated.
  input wire logic drive, // One-cycle drive pulse into the first stage.
  input wire logic [tcds_pkg::TCDS_CNT_BITS-1:0] stage_mask, // Stages allowed to toggle.
  output logic [tcds_pkg::TCDS_CNT_BITS-1:0] count // Present stage states.
);
  import tcds_pkg::*;

  logic [TCDS_CNT_BITS-1:0] toggle;
  logic [TCDS_CNT_BITS-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // The first stage follows the drive; each later stage toggles when the one before turns off.
  assign toggle[0] = drive & stage_mask[0];
  genvar i;
  generate
    for (i = 1; i < TCDS_CNT_BITS; i++) begin : g_stage
      assign toggle[i] = toggle[i-1] & count[i-1] & stage_mask[i];
    end
  endgenerate

  // Next stage values; blocked stages stay where they are, and hold_reset clears every stage.
  always_comb begin
    if (hold_reset) begin
      next_count = '0;
    end else begin
      next_count = count ^ toggle;
    end
  end

  // Stage flip-flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// *** design/tcds_status.sv ***
// Purpose: Status latches that assemble the initial and ending status byte.
// Assumes: Set and clear requests are single-cycle pulses on the system clock.
// Notes: A set in the same cycle as a clear wins, so no condition is lost.
module tcds_status (
  input wire logic clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [7:0] set_bits, // Status conditions to latch, byte bit order.
  input wire logic clear, // Status reset: accepted status or machine reset.
  output logic [7:0] status_byte // Latched status, positions 1 and 3 only for busy use.
);
  import tcds_pkg::*;

  logic [7:0] next_status_byte;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Five basic latches plus two busy latches; position 0 never holds a bit.
  always_comb begin
    next_status_byte = status_byte;
    if (clear) begin
      next_status_byte = '0;
    end
    next_status_byte = next_status_byte
      | (set_bits & (TCDS_SB_BASIC_MASK | TCDS_SB_BUSY_MASK));
  end

  // Status latch flip-flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_byte <= '0;
    end else begin
      status_byte <= next_status_byte;
    end
  end

endmodule

// *** design/tcds_core.sv ***
// Purpose: Tape control inbound holding register, status latches and timing counter core.
// Assumes: Channel handshake inputs and read clock steps are synchronous to clk.
// Notes: Registers sit behind an Avalon-MM slave answering one cycle after the request.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
module tcds_core (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [7:0] avs_address, // Avalon byte address.
  input wire logic avs_read, // Avalon read request.
  input wire logic avs_write, // Avalon write request.
  input wire logic [31:0] avs_writedata, // Avalon write data.
  input wire logic [3:0] avs_byteenable, // Avalon byte enables.
  output logic [31:0] avs_readdata, // Avalon read data.
  output logic avs_waitrequest, // Avalon wait request.
  input wire logic service_out, // Channel service out.
  input wire logic command_out, // Channel command out.
  input wire logic [7:0] bus_out, // Channel bus out byte.
  output logic status_in, // Status in to the channel.
  output logic service_in, // Service in to the channel.
  output logic [7:0] bus_in, // Bus in byte to the channel.
  input wire logic [7:0] read_byte, // Byte from the read register or translator.
  input wire logic read_clock_strobe, // One-cycle pulse when the read clock steps.
  input wire logic [3:0] read_clock, // Read clock step number.
  input wire logic [2:0] unit_not_ready, // Not-ready lines from the attached tape units.
  output logic [7:0] write_out // Byte to the tape write circuits.
);
  import tcds_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [2:0] units;
  logic [2:0] next_units;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [4:0] cmd_pulse;
  logic [4:0] next_cmd_pulse;
  logic [7:0] status_set;
  logic [7:0] next_status_set;
  logic [15:0] slow_div;
  logic [15:0] next_slow_div;
  logic [7:0] fast_div;
  logic [7:0] next_fast_div;
  logic slow_tick;
  logic fast_tick;
  logic [TCDS_HR_BITS:1] holding_register;
  logic [TCDS_HR_BITS:1] next_holding_register;
  logic next_status_in;
  logic next_service_in;
  logic [7:0] next_bus_in;
  logic [7:0] next_write_out;
  logic stacked;
  logic next_stacked;
  logic counter_check;
  logic next_counter_check;
  logic cmd_refused;
  logic next_cmd_refused;
  logic cmd_accepted;
  logic next_cmd_accepted;
  logic wc_at_last;
  logic next_wc_at_last;
  logic [7:0] status_byte;
  logic [TCDS_CNT_BITS-1:0] count;
  tcds_mode_type mode;
  logic [TCDS_CNT_BITS-1:0] stage_mask;
  logic cnt_drive;
  logic bus_we;
  logic bus_re;
  logic machine_reset;
  logic status_accept;
  logic stack_status;
  logic stop_command;
  logic rd_op;
  logic inbound_read;
  logic inbound_status;
  logic inbound_sense;
  logic wc15_reset;
  logic endop_reset;
  logic reset_low;
  logic reset_high;
  logic check_hit;
  logic [7:0] status_gated;
  logic [7:0] sense_byte;

  // Sense byte selected by the decoded sense count.
  function automatic logic [7:0] tcds_sense_sel(input logic [2:0] cnt,
                                                input logic [2:0] nr,
                                                input logic [2:0] present);
    logic [7:0] b;
    b = 8'h00;
    if (cnt == TCDS_SENSE_UNITS) begin
      b = {5'h00, nr & present};
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Oscillator dividers give one-cycle slow and fast drive pulses.
  assign slow_tick = (slow_div == 16'(TCDS_SLOW_DIV - 1));
  assign fast_tick = (fast_div == 8'(TCDS_FAST_DIV - 1));

  always_comb begin
    next_slow_div = slow_tick ? 16'h0000 : slow_div + 16'h0001;
    next_fast_div = fast_tick ? 8'h00 : fast_div + 8'h01;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_div <= 16'h0000;
      fast_div <= 8'h00;
    end else begin
      slow_div <= next_slow_div;
      fast_div <= next_fast_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: each request is answered at the edge after it is first seen.
  assign bus_we = avs_write & ~avs_waitrequest;
  assign bus_re = avs_read & ~avs_waitrequest;

  always_comb begin
    next_waitrequest = 1'b1;
    if ((avs_read | avs_write) & avs_waitrequest) begin
      next_waitrequest = 1'b0;
    end
    next_ctrl = ctrl;
    next_units = units;
    next_cmd_pulse = '0;
    next_status_set = '0;
    if (bus_we & avs_byteenable[0]) begin
      unique case (avs_address)
        TCDS_OFF_CTRL: next_ctrl = avs_writedata[7:0];
        TCDS_OFF_CMD: next_cmd_pulse = avs_writedata[4:0];
        TCDS_OFF_UNITS: next_units = avs_writedata[2:0];
        TCDS_OFF_STSET: next_status_set = avs_writedata[7:0];
        default: next_ctrl = ctrl;
      endcase
    end
    next_readdata = 32'h00000000;
    if ((avs_read | avs_write) & avs_waitrequest & avs_read) begin
      unique case (avs_address)
        TCDS_OFF_CTRL: next_readdata = {24'h000000, ctrl};
        TCDS_OFF_UNITS: next_readdata = {29'h00000000, units};
        TCDS_OFF_STATUS: next_readdata = {18'h00000, service_in, status_in, cmd_accepted,
                                          cmd_refused, counter_check, stacked, status_byte};
        TCDS_OFF_HOLD: next_readdata = {20'h00000, holding_register};
        TCDS_OFF_COUNT: next_readdata = {21'h000000, count};
        default: next_readdata = 32'h00000000;
      endcase
    end else if (bus_re) begin
      next_readdata = avs_readdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl <= TCDS_CTRL_RESET;
      units <= 3'h0;
      cmd_pulse <= 5'h00;
      status_set <= 8'h00;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      ctrl <= next_ctrl;
      units <= next_units;
      cmd_pulse <= next_cmd_pulse;
      status_set <= next_status_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Channel responses decoded into the reset events.
  assign rd_op = ctrl[TCDS_CTRL_RDFWD] | ctrl[TCDS_CTRL_RDBWD];
  assign machine_reset = cmd_pulse[TCDS_CMD_MRESET];
  assign status_accept = status_in & service_out;
  assign stack_status = status_in & command_out;
  assign stop_command = service_in & command_out
    & (ctrl[TCDS_CTRL_SENSE] | ctrl[TCDS_CTRL_WRITE] | rd_op);
  assign wc15_reset = ctrl[TCDS_CTRL_WDISC] & ctrl[TCDS_CTRL_WRITE] & ~wc_at_last
    & (count[3:0] == TCDS_WC_LAST);
  assign endop_reset = cmd_pulse[TCDS_CMD_ENDOP] & ctrl[TCDS_CTRL_STOPDLY];

  // The two reset groups are driven by the same events, so both halves always clear together.
  assign reset_low = stop_command | stack_status | status_accept | wc15_reset
    | endop_reset;
  assign reset_high = stop_command | stack_status | status_accept | wc15_reset
    | endop_reset;

  // Inbound gate conditions.
  assign inbound_read = rd_op & read_clock_strobe & (read_clock == TCDS_RC_LOAD);
  assign inbound_status = cmd_pulse[TCDS_CMD_PRESENT] & ~status_in;
  assign inbound_sense = ctrl[TCDS_CTRL_SENSE] & read_clock_strobe
    & (read_clock == TCDS_RC_LOAD);
  assign sense_byte = tcds_sense_sel(count[2:0], unit_not_ready, units);

  // Status byte gated out; only the modifier may occupy positions 0 and 1.
  assign status_gated = {status_byte[7:2], status_byte[TCDS_SB_MODIFIER], 1'b0};

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Holding register, channel handshake and output paths.
  always_comb begin
    next_holding_register = holding_register;
    if (reset_low) begin
      next_holding_register[TCDS_HR_SPLIT:1] = '0;
    end
    if (reset_high) begin
      next_holding_register[TCDS_HR_BITS:TCDS_HR_SPLIT+1] = '0;
    end
    // Only the three inbound cases and the write transfer may load positions 5 to 12.
    if (inbound_read) begin
      next_holding_register[TCDS_HR_BITS:TCDS_HR_BASE] = read_byte;
    end else if (inbound_status) begin
      next_holding_register[TCDS_HR_BITS:TCDS_HR_BASE] = status_gated;
      next_holding_register[TCDS_HR_CUEND_POS] = status_byte[TCDS_SB_CUEND];
    end else if (inbound_sense) begin
      next_holding_register[TCDS_HR_BITS:TCDS_HR_BASE] = sense_byte;
    end else if (ctrl[TCDS_CTRL_WRITE] & service_in & service_out) begin
      next_holding_register[TCDS_HR_BITS:TCDS_HR_BASE] = bus_out;
    end
    // Status in rises on presentation and drops on any channel answer.
    next_status_in = status_in;
    if (status_accept | stack_status | machine_reset) begin
      next_status_in = 1'b0;
    end else if (inbound_status) begin
      next_status_in = 1'b1;
    end
    // Service in requests a byte transfer for data operations.
    next_service_in = service_in;
    if (service_out | command_out | machine_reset) begin
      next_service_in = 1'b0;
    end else if (inbound_read | inbound_sense) begin
      next_service_in = 1'b1;
    end else if (ctrl[TCDS_CTRL_WRITE] & ~ctrl[TCDS_CTRL_WDISC] & fast_tick
                 & (count[3:0] == TCDS_WC_LAST)) begin
      next_service_in = 1'b1;
    end
    // Bus in takes the AND-side output, the write path the OR-side output.
    next_bus_in = (status_in | service_in) ? holding_register[12:5] : 8'h00;
    next_write_out = holding_register[12:5] | 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holding_register <= '0;
      status_in <= 1'b0;
      service_in <= 1'b0;
      bus_in <= 8'h00;
      write_out <= 8'h00;
    end else begin
      holding_register <= next_holding_register;
      status_in <= next_status_in;
      service_in <= next_service_in;
      bus_in <= next_bus_in;
      write_out <= next_write_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Command acceptance, stacked status and counter check flags.
  always_comb begin
    next_stacked = stacked;
    if (status_accept | machine_reset) begin
      next_stacked = 1'b0;
    end
    if (stack_status) begin
      next_stacked = 1'b1;
    end
    next_cmd_refused = cmd_refused;
    next_cmd_accepted = cmd_accepted;
    if (cmd_pulse[TCDS_CMD_START]) begin
      if (stacked) begin
        next_cmd_refused = 1'b1;
        next_cmd_accepted = 1'b0;
      end else if (cmd_pulse[TCDS_CMD_CONTROL]) begin
        next_cmd_accepted = ((status_byte & ~(8'h01 << TCDS_SB_CHEND)) == 8'h00);
        next_cmd_refused = ~next_cmd_accepted;
      end else begin
        next_cmd_accepted = (status_byte == 8'h00);
        next_cmd_refused = ~next_cmd_accepted;
      end
    end
    next_counter_check = counter_check;
    if (machine_reset) begin
      next_counter_check = 1'b0;
    end
    if (check_hit) begin
      next_counter_check = 1'b1;
    end
    next_wc_at_last = (count[3:0] == TCDS_WC_LAST);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stacked <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_accepted <= 1'b0;
      counter_check <= 1'b0;
      wc_at_last <= 1'b0;
    end else begin
      stacked <= next_stacked;
      cmd_refused <= next_cmd_refused;
      cmd_accepted <= next_cmd_accepted;
      counter_check <= next_counter_check;
      wc_at_last <= next_wc_at_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Status latches; the counter check raises unit check.
  assign check_hit = (count == TCDS_CNT_CHECK);

  tcds_status u_status (
    .clk(clk),
    .rst(rst),
    .set_bits(status_set | ({7'h00, check_hit} << TCDS_SB_UNITCHK)),
    .clear(status_accept | machine_reset),
    .status_byte(status_byte)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Counter mode selection, drive source and stage blocking.
  always_comb begin
    mode = TCDS_MODE_IDLE;
    if (ctrl[TCDS_CTRL_MECH]) begin
      mode = TCDS_MODE_MECH;
    end else if (ctrl[TCDS_CTRL_WRITE] & ctrl[TCDS_CTRL_WDISC]) begin
      mode = TCDS_MODE_WDISC;
    end else if (ctrl[TCDS_CTRL_WRITE]) begin
      mode = TCDS_MODE_WRITE;
    end else if (ctrl[TCDS_CTRL_EOB]) begin
      mode = TCDS_MODE_EOB;
    end else if (ctrl[TCDS_CTRL_SENSE]) begin
      mode = TCDS_MODE_SENSE;
    end
    cnt_drive = 1'b0;
    stage_mask = '0;
    unique case (mode)
      TCDS_MODE_IDLE: begin
        cnt_drive = 1'b0;
        stage_mask = '0;
      end
      TCDS_MODE_WRITE: begin
        cnt_drive = fast_tick;
        stage_mask = TCDS_MASK_WRITE;
      end
      TCDS_MODE_WDISC: begin
        cnt_drive = fast_tick;
        stage_mask = TCDS_MASK_WDISC;
      end
      TCDS_MODE_EOB: begin
        cnt_drive = fast_tick;
        stage_mask = TCDS_MASK_ALL;
      end
      TCDS_MODE_MECH: begin
        cnt_drive = slow_tick;
        stage_mask = TCDS_MASK_ALL;
      end
      TCDS_MODE_SENSE: begin
        cnt_drive = read_clock_strobe & (read_clock == TCDS_RC_SENSE);
        stage_mask = TCDS_MASK_SENSE;
      end
    endcase
  end

  tcds_counter u_counter (
    .clk(clk),
    .rst(rst),
    .hold_reset(mode == TCDS_MODE_IDLE),
    .drive(cnt_drive),
    .stage_mask(stage_mask),
    .count(count)
  );

endmodule

// *** tb/tcds_core_chk.sv ***
// Purpose: Port checks on channel answers and bus timing.
// Assumes: One clock, rst async and active high.
// Notes: Bound to every tcds_core instance.
module tcds_chk (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic avs_read, // Read.
  input wire logic avs_write, // Write.
  input wire logic avs_waitrequest, // Wait.
  input wire logic service_out, // Accept.
  input wire logic command_out, // Stack or stop.
  input wire logic status_in, // Status.
  input wire logic service_in, // Data.
  input wire logic [7:0] bus_in // Byte.
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // An answer from the channel ends the offer on the next edge; an accepted byte is gone from bus in three edges later.
  a_accept_drops: assert property (status_in && service_out |=> !status_in)
    else $error("Status kept after acceptance.");
  a_stack_drops: assert property (status_in && command_out |=> !status_in)
    else $error("Status kept after stacking.");
  a_stop_drops: assert property (service_in && command_out |=> !service_in)
    else $error("Data offer kept after stop.");
  a_hr_cleared: assert property (status_in && service_out && !service_in |-> ##3 !bus_in)
    else $error("Byte kept after acceptance.");
  // Leading position stays clear while a status byte stands.
  a_lead_zero: assert property (status_in && $past(status_in) |-> !bus_in[0])
    else $error("Leading status position set.");
  a_bus_quiet: assert property (!(status_in || service_in || $past(status_in)
    || $past(service_in)) |-> bus_in == 8'h00)
    else $error("Bus in driven while idle.");
  // Each request is answered one cycle later, for one cycle.
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Request not answered.");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Answer held too long.");
endmodule
bind tcds_core tcds_chk u_chk (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .service_out, .command_out, .status_in, .service_in, .bus_in);

// *** tb/tcds_chan.sv ***
// Purpose: Channel model answering status and data offers.
// Assumes: Answer kind and delay set by the bench.
// Notes: Idle bus out toggles so stale bytes never look valid.
module tcds_chan (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic status_in, // Status offer.
  input wire logic service_in, // Data offer.
  input wire logic stack, // Answer by command out.
  input wire logic [7:0] dly, // Answer delay.
  output logic service_out, // Accept.
  output logic command_out, // Stack or stop.
  output logic [7:0] bus_out // Byte.
);
  logic [7:0] cnt;
  // Answer after dly cycles and hold until the offer is withdrawn.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      service_out <= 1'b0;
      command_out <= 1'b0;
      bus_out <= 8'h00;
    end else if (!status_in && !service_in) begin
      cnt <= 8'h00;
      service_out <= 1'b0;
      command_out <= 1'b0;
      bus_out <= ~bus_out;
    end else if (cnt == dly) begin
      service_out <= !stack;
      command_out <= stack;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// *** tb/tb_tape_control_data_status_counter.sv ***
// Purpose: Self-checking bench for the tape control core.
// Assumes: Register map and timing as handed over.
// Notes: Channel answers come from the tcds_chan model.
module tb_tape_control_data_status_counter;
  timeunit 1ns;
  timeprecision 1ns;
  import tcds_pkg::*;
  logic clk, rst, avs_read, avs_write, read_clock_strobe, stack, avs_waitrequest;
  logic service_out, command_out, status_in, service_in;
  logic [7:0] avs_address, read_byte, dly, bus_in, bus_out, write_out;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] read_clock;
  logic [2:0] unit_not_ready;
  logic [15:0] rows [2] = '{16'hFFFE, 16'h4A4A};
  int errors, tests_run;
  tcds_core uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .service_out, .command_out,
    .bus_out, .status_in, .service_in, .bus_in, .read_byte, .read_clock_strobe,
    .read_clock, .unit_not_ready, .write_out);
  tcds_chan chan (.clk, .rst, .status_in, .service_in, .stack, .dly, .service_out,
    .command_out, .bus_out);
  // Clock of 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Verdict and end of run.
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One register access, held until waitrequest is seen low.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    // Waitrequest is read at each rising edge, before the slave updates it.
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      errors++;
      stop_test;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Bounded wait for status_in (s=0) or service_in (s=1) to reach v.
  task wt(input logic v, input logic s);
    int n;
    for (n = 0; n < 200 && (s ? service_in : status_in) !== v; n++) @(negedge clk);
    if (n == 200) begin
      errors++;
      stop_test;
    end
  endtask
  task step(input logic [3:0] s);
    @(posedge clk);
    read_clock <= s;
    read_clock_strobe <= 1'b1;
    @(posedge clk);
    read_clock_strobe <= 1'b0;
  endtask
  // Main sequence.
  initial begin
    {rst, avs_read, avs_write, read_clock_strobe, stack} = 5'h10;
    {avs_address, avs_writedata, read_byte, read_clock, unit_not_ready} = '0;
    dly = 8'h1E;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      bus(1, TCDS_OFF_STSET, {24'h0, rows[i][15:8]});
      bus(0, TCDS_OFF_STATUS, 0);
      chk(rd & 32'hFF, {24'h0, rows[i][7:0]});
      bus(1, TCDS_OFF_CMD, 32'h10);
      bus(0, TCDS_OFF_STATUS, 0);
      chk(rd & 32'hFF, 0);
    end
    bus(1, TCDS_OFF_STSET, 32'h34);
    bus(1, TCDS_OFF_CMD, 32'h1);
    wt(1, 0);
    bus(0, TCDS_OFF_HOLD, 0);
    chk(rd, 32'h340);
    chk({24'h0, bus_in}, 32'h34);
    chk({24'h0, write_out}, 32'h34);
    wt(0, 0);
    bus(0, TCDS_OFF_STATUS, 0);
    chk(rd & 32'hFF, 0);
    stack <= 1'b1;
    bus(1, TCDS_OFF_STSET, 32'h30);
    bus(1, TCDS_OFF_CMD, 32'h1);
    wt(1, 0);
    wt(0, 0);
    bus(1, TCDS_OFF_CMD, 32'h2);
    bus(0, TCDS_OFF_STATUS, 0);
    chk(rd & 32'h5FF, 32'h530);
    bus(1, TCDS_OFF_CMD, 32'h10);
    bus(1, TCDS_OFF_STSET, 32'h10);
    bus(1, TCDS_OFF_CMD, 32'h6);
    bus(0, TCDS_OFF_STATUS, 0);
    chk(rd & 32'h800, 32'h800);
    stack <= 1'b0;
    read_byte <= 8'hA5;
    step(4'h8);
    bus(0, TCDS_OFF_HOLD, 0);
    chk(rd, 0);
    bus(1, TCDS_OFF_CTRL, 32'h1);
    step(4'h8);
    wt(1, 1);
    bus(0, TCDS_OFF_HOLD, 0);
    chk(rd, 32'hA50);
    wt(0, 1);
    bus(1, TCDS_OFF_CMD, 32'h8);
    bus(0, TCDS_OFF_HOLD, 0);
    chk(rd, 32'hA50);
    bus(1, TCDS_OFF_CTRL, 32'h81);
    bus(1, TCDS_OFF_CMD, 32'h8);
    bus(0, TCDS_OFF_HOLD, 0);
    chk(rd, 0);
    stack <= 1'b1;
    step(4'h8);
    wt(1, 1);
    wt(0, 1);
    bus(0, TCDS_OFF_HOLD, 0);
    chk(rd, 0);
    bus(1, TCDS_OFF_CTRL, 32'h8);
    repeat (9) step(4'h7);
    bus(0, TCDS_OFF_COUNT, 0);
    chk(rd, 1);
    bus(1, TCDS_OFF_UNITS, 32'h3);
    unit_not_ready <= 3'h7;
    step(4'h8);
    wt(1, 1);
    bus(0, TCDS_OFF_HOLD, 0);
    chk(rd, 32'h30);
    stop_test;
  end
endmodule
